// File: ssbc_pkg.sv
// Constants and types for the SPI shift buffer control block.
package ssbc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] SSBC_CTRL_OFS   = 4'h0;
  localparam logic [3:0] SSBC_STAT_OFS   = 4'h4;
  localparam logic [3:0] SSBC_BUF_OFS    = 4'h8;
  localparam logic [3:0] SSBC_IFLAG_OFS  = 4'hC;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SSBC_WRITE_COLLISION_FLAG_BIT  = 7;
  localparam int SSBC_OVF_BIT   = 6;
  localparam int SSBC_EN_BIT    = 5;
  localparam int SSBC_CKP_BIT   = 4;
  localparam int SSBC_SMP_BIT   = 7;
  localparam int SSBC_CKE_BIT   = 6;
  localparam int SSBC_BF_BIT    = 0;
  localparam logic [7:0] SSBC_CTRL_RST = 8'h00;
  localparam logic [7:0] SSBC_STAT_RST = 8'h00;
  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [3:0] SSBC_M_DIV4   = 4'h0;
  localparam logic [3:0] SSBC_M_DIV16  = 4'h1;
  localparam logic [3:0] SSBC_M_DIV64  = 4'h2;
  localparam logic [3:0] SSBC_M_TMR2   = 4'h3;
  localparam logic [3:0] SSBC_M_SLVSS  = 4'h4;
  localparam logic [3:0] SSBC_M_SLV    = 4'h5;
  // ----------------------------------------
  // Timing counts (half periods of the serial clock, in system cycles) and the index of the last bit
  // ----------------------------------------
  localparam logic [5:0] SSBC_HALF_DIV4  = 6'h02;
  localparam logic [5:0] SSBC_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SSBC_HALF_DIV64 = 6'h20;
  localparam logic [2:0] SSBC_LAST_BIT   = 3'h7;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] stat_cfg;
    logic       bf;
    logic       iflag;
    logic [7:0] buf_r;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic       busy;
    logic       sck;
    logic       sdo;
    logic [5:0] div;
    logic       t2_tog;
    logic [2:0] sck_s;
    logic       sck_lvl;
    logic [2:0] sdi_s;
    logic [2:0] ss_s;
    logic       ack;
    logic [7:0] dat;
  } ssbc_state_t;
endpackage

// File: ssbc_top.sv
// SPI shift register, receive buffer and flags behind a Wishbone slave.
`timescale 1ns/1ps
module ssbc_top
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic     [31:0] wb_dat_o,
  output logic            wb_ack_o,
  // Timer two output
  input  wire logic       timer_two_i,
  // SPI pins
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  input  wire logic       ss_n_i
);
  import ssbc_pkg::*;

  ssbc_state_t q, d;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic is_master(input logic [3:0] m);
    is_master = (m <= SSBC_M_TMR2);
  endfunction

  logic       en, clock_idle_polarity, cke, input_sample_phase, master, req, wr, rd, lane0;
  logic       sck_f, sck_rise, sck_fall, lead, trail, ss_hi, rx_bit;
  logic       tick, t2_rise;
  logic [5:0] half;
  logic       done;
  logic [7:0] rdata;

  always_comb
  begin
    en       = q.ctrl[SSBC_EN_BIT];
    clock_idle_polarity      = q.ctrl[SSBC_CKP_BIT];
    cke      = q.stat_cfg[1];
    input_sample_phase      = q.stat_cfg[0];
    master   = is_master(q.ctrl[3:0]);
    req      = wb_cyc_i && wb_stb_i && !q.ack;
    wr       = req && wb_we_i;
    rd       = req && !wb_we_i;
    lane0    = wb_sel_i[0];
    // Glitch filter: a pin level counts when the two late stages agree.
    sck_f    = (q.sck_s[2] == q.sck_s[1]) ? q.sck_s[1] : q.sck_lvl;
    sck_rise = sck_f && !q.sck_lvl;
    sck_fall = !sck_f && q.sck_lvl;
    // In master mode the reply follows our own clock, and a half period of two
    // cycles leaves no room for the full pin delay, so the first stage is used.
    rx_bit   = master ? q.sdi_s[0] : q.sdi_s[2];
    ss_hi    = (q.ctrl[3:0] == SSBC_M_SLVSS) && q.ss_s[2] && q.ss_s[1];
    t2_rise  = timer_two_i && !q.t2_tog;
    unique case (q.ctrl[3:0])
      SSBC_M_DIV16: half = SSBC_HALF_DIV16;
      SSBC_M_DIV64: half = SSBC_HALF_DIV64;
      default:      half = SSBC_HALF_DIV4;
    endcase
    if (q.ctrl[3:0] == SSBC_M_TMR2)
      tick = t2_rise;
    else
      tick = (q.div == half - 6'h01);
    // Leading edge leaves idle; trailing edge returns to idle.
    if (master)
    begin
      lead  = tick && q.busy && (q.sck == clock_idle_polarity);
      trail = tick && q.busy && (q.sck != clock_idle_polarity);
    end
    else
    begin
      lead  = clock_idle_polarity ? sck_fall : sck_rise;
      trail = clock_idle_polarity ? sck_rise : sck_fall;
    end
    unique case (wb_adr_i)
      SSBC_CTRL_OFS:  rdata = q.ctrl;
      SSBC_STAT_OFS:  rdata = {q.stat_cfg, 5'h00, q.bf};
      SSBC_BUF_OFS:   rdata = q.buf_r;
      SSBC_IFLAG_OFS: rdata = {7'h00, q.iflag};
      default:        rdata = 8'h00;
    endcase
  end

  logic sample, shift_out, ovf_set;
  always_comb
  begin
    // CKE=1 changes data on the trailing edge; INPUT_SAMPLE_PHASE=1 samples a half later.
    shift_out = cke ? trail : lead;
    sample    = (cke ^ input_sample_phase) ? lead : trail;
    done      = 1'b0;
    ovf_set   = 1'b0;
    d = q;
    d.sck_lvl = sck_f;
    d.sck_s  = {q.sck_s[1:0], sck_i};
    d.sdi_s  = {q.sdi_s[1:0], sdi_i};
    d.ss_s   = {q.ss_s[1:0], ss_n_i};
    d.t2_tog = timer_two_i;
    d.ack    = req;
    if (req)
      d.dat = rdata;
    d.div = (tick || !q.busy) ? 6'h00 : q.div + 6'h01;
    if (!master || !q.busy)
      d.sck = clock_idle_polarity;
    else if (tick)
      d.sck = !q.sck;
    if (sample)
      d.shreg = {q.shreg[6:0], rx_bit};
    if (shift_out && !(cke && q.bitcnt == 3'h0 && master))
      d.sdo = q.shreg[7];
    if (sample && (q.busy || !master))
    begin
      d.busy   = 1'b1;
      d.bitcnt = q.bitcnt + 3'h1;
      if (q.bitcnt == SSBC_LAST_BIT)
      begin
        done   = 1'b1;
        d.busy = 1'b0;
      end
    end
    // Received byte moves to the buffer unless a slave finds it still full; the new byte can already start.
    if (done)
    begin
      if (q.bf && !master)
      begin
        ovf_set = 1'b1;
        d.ctrl[SSBC_OVF_BIT] = 1'b1;
      end
      else
      begin
        d.buf_r = {q.shreg[6:0], rx_bit};
        d.bf    = 1'b1;
        d.iflag = 1'b1;
      end
    end
    if (rd && lane0 && wb_adr_i == SSBC_BUF_OFS && !done)
      d.bf = 1'b0;
    if (wr && lane0)
    begin
      unique case (wb_adr_i)
        SSBC_CTRL_OFS:
        begin
          d.ctrl[5:0] = wb_dat_i[5:0];
          d.ctrl[SSBC_WRITE_COLLISION_FLAG_BIT] = wb_dat_i[7] & q.ctrl[7];
          d.ctrl[SSBC_OVF_BIT]  = (wb_dat_i[6] & q.ctrl[6]) | ovf_set;
        end
        SSBC_STAT_OFS:  d.stat_cfg = wb_dat_i[7:6];
        SSBC_IFLAG_OFS: d.iflag = d.iflag & !wb_dat_i[0] | done;
        SSBC_BUF_OFS:
          if (q.busy || q.bitcnt != 3'h0)
            d.ctrl[SSBC_WRITE_COLLISION_FLAG_BIT] = 1'b1;
          else
          begin
            d.shreg = wb_dat_i[7:0];
            d.sdo   = wb_dat_i[7];
            d.busy  = master && en;
          end
        default: ;
      endcase
    end
    if (!en || ss_hi)
    begin
      d.bitcnt = 3'h0;
      d.busy   = 1'b0;
      d.sck    = clock_idle_polarity;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.ctrl <= SSBC_CTRL_RST;
      q.stat_cfg <= SSBC_STAT_RST[7:6];
    end
    else
      q <= d;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.dat};
  assign sck_o    = q.sck;
  assign sck_oe_o = en && master;
  assign sdo_o    = q.sdo;
  assign sdo_oe_o = en && !(q.ctrl[3:0] == SSBC_M_SLVSS && q.ss_s[2]);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  done_sets_bf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done && !(q.bf && !master) |=> q.bf && q.iflag)
    else $error("byte done without buffer full");
  write_collision_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && lane0 && wb_adr_i == SSBC_BUF_OFS && q.busy && !sample |=> q.ctrl[7] && $stable(q.shreg))
    else $error("collision not flagged");
  write_collision_flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ctrl[7] && !(wr && wb_adr_i == SSBC_CTRL_OFS) |=> q.ctrl[7])
    else $error("collision flag cleared by hardware");
  bf_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && lane0 && wb_adr_i == SSBC_BUF_OFS && !done |=> !q.bf)
    else $error("read did not clear buffer full");
  no_ovf_master_a: assert property (@(posedge clk_i) disable iff (rst_i)
    master && !q.ctrl[6] && !(wr && wb_adr_i == SSBC_CTRL_OFS) |=> !q.ctrl[6])
    else $error("overflow in master mode");
  ovf_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done && q.bf && !master |=> q.ctrl[6] && $stable(q.buf_r))
    else $error("overflow lost old byte");
  idle_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.busy && !$past(q.busy) && $past(clock_idle_polarity) == clock_idle_polarity |-> q.sck == clock_idle_polarity)
    else $error("clock not idle level");
  disable_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en |=> q.bitcnt == 3'h0 && !q.busy)
    else $error("disable did not reset counter");
  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !q.ack |=> q.ack ##1 !q.ack)
    else $error("ack not single cycle");
  cov_master_c: cover property (@(posedge clk_i) disable iff (rst_i) master && done);
  cov_slave_c: cover property (@(posedge clk_i) disable iff (rst_i) !master && done);
  cov_write_collision_flag_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q.ctrl[7]));
  cov_ovf_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q.ctrl[6]));
endmodule

// File: ssbc_slave_model.sv
// Behavioural SPI slave facing the block when it runs as master.
`timescale 1ns/1ps
module ssbc_slave_model
(
  // Serial pins
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // Bench side
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  output logic      [7:0] rx_o
);
  logic [7:0] sh_q;
  int         cnt;
  initial miso_o = 1'b0;
  // The first bit must stand before the first rising edge, so it is shown at load time.
  always @(posedge load_i)
  begin
    sh_q = tx_i;
    cnt = 0;
    miso_o = tx_i[7];
  end
  always @(posedge sck_i)
    rx_o = {rx_o[6:0], mosi_i};
  // After the last bit the line is released, shown as the inverse of its last level.
  always @(negedge sck_i)
  begin
    cnt = cnt + 1;
    sh_q = sh_q << 1;
    miso_o = (cnt < 8) ? sh_q[7] : ~miso_o;
  end
endmodule

// File: spi_shift_buffer_control_tb.sv
// Self-checking bench: register access, master transfers and slave reception.
`timescale 1ns/1ps
module spi_shift_buffer_control_tb;
  import ssbc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rv;
  logic        wb_ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, miso, sdi_i;
  logic        timer_two_i = 1'b0;
  logic        sck_i = 1'b0;
  logic        slv_sdi = 1'b0;
  logic        slave_run = 1'b0;
  logic        ss_n_i = 1'b1;
  logic        pl_load = 1'b0;
  logic [7:0]  pl_tx = 8'h00;
  logic [7:0]  pl_rx, t, p;
  logic [3:0]  m;
  int          err_count = 0;
  int          samples_checked = 0;
  int          n;
  assign sdi_i = slave_run ? slv_sdi : miso;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) timer_two_i <= ~timer_two_i;
  ssbc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_two_i, .sck_i, .sck_o, .sck_oe_o, .sdi_i,
    .sdo_o, .sdo_oe_o, .ss_n_i);
  ssbc_slave_model peer (.sck_i(sck_o), .mosi_i(sdo_o), .miso_o(miso), .load_i(pl_load),
    .tx_i(pl_tx), .rx_o(pl_rx));
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    for (int i = 0; i < 50 && wb_ack_o !== 1'b1; i++)
      @(posedge clk_i);
    if (wb_ack_o !== 1'b1)
      err_count++;
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Polling status instead of writing blindly avoids a needless collision.
  task automatic wait_bf;
    rv = 32'h0;
    for (int i = 0; i < 300 && rv[0] !== 1'b1; i++)
      wb(1'b0, SSBC_STAT_OFS, 8'h00);
  endtask
  // Link clock of 200 ns: data changes with the rising edge, the block samples on the fall.
  task automatic sbits(input logic [7:0] tx, input int cnt);
    for (int i = 7; i > 7 - cnt; i--)
    begin
      sck_i <= 1'b1;
      slv_sdi <= tx[i];
      repeat (4) @(posedge clk_i);
      sck_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    slv_sdi <= ~slv_sdi;
    repeat (8) @(posedge clk_i);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, SSBC_CTRL_OFS, 8'h00);
    chk("ctrl", rv, 32'h0);
    wb(1'b0, SSBC_STAT_OFS, 8'h00);
    chk("stat", rv, 32'h0);
    wb(1'b0, 4'h2, 8'h00);
    chk("unmapped", rv, 32'h0);
    wb(1'b1, SSBC_STAT_OFS, 8'h40);
    wb(1'b1, SSBC_CTRL_OFS, 8'hE0);
    wb(1'b0, SSBC_CTRL_OFS, 8'h00);
    chk("ctrl", rv, 32'h20);
    wb(1'b0, SSBC_STAT_OFS, 8'h00);
    chk("stat", rv, 32'h40);
    chk("sck idle", 32'(sck_o), 32'h0);
    chk("sck oe", 32'(sck_oe_o), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      m = 4'(k);
      t = 8'h3C + {4'h0, m};
      p = 8'hA5 ^ {4'h0, m};
      wb(1'b1, SSBC_CTRL_OFS, {4'hE, m});
      pl_tx <= p;
      pl_load <= 1'b1;
      wb(1'b1, SSBC_BUF_OFS, t);
      pl_load <= 1'b0;
      wb(1'b1, SSBC_BUF_OFS, 8'hFF);
      if (k < 3)
      begin
        while (sck_o !== 1'b0) @(posedge clk_i);
        while (sck_o !== 1'b1) @(posedge clk_i);
        for (n = 0; sck_o === 1'b1; n++) @(posedge clk_i);
        chk("half period", 32'(n), 32'(k == 0 ? SSBC_HALF_DIV4 :
          k == 1 ? SSBC_HALF_DIV16 : SSBC_HALF_DIV64));
      end
      wait_bf;
      chk("peer rx", {24'h0, pl_rx}, {24'h0, t});
      wb(1'b0, SSBC_BUF_OFS, 8'h00);
      chk("buffer", rv, {24'h0, p});
      wb(1'b0, SSBC_STAT_OFS, 8'h00);
      chk("bf after read", rv, 32'h40);
      wb(1'b0, SSBC_IFLAG_OFS, 8'h00);
      chk("iflag", rv, 32'h1);
      wb(1'b1, SSBC_IFLAG_OFS, 8'h01);
      wb(1'b0, SSBC_CTRL_OFS, 8'h00);
      chk("ctrl write_collision_flag", rv, {24'h0, 4'hA, m});
      wb(1'b1, SSBC_CTRL_OFS, {4'h4, m});
      wb(1'b0, SSBC_CTRL_OFS, 8'h00);
      chk("ctrl clear", rv, {24'h0, 4'h0, m});
    end
    wb(1'b1, SSBC_CTRL_OFS, 8'h70);
    chk("sck idle high", 32'(sck_o), 32'h1);
    wb(1'b1, SSBC_CTRL_OFS, 8'h40);
    wb(1'b1, SSBC_STAT_OFS, 8'h00);
    slave_run <= 1'b1;
    wb(1'b1, SSBC_CTRL_OFS, 8'h65);
    chk("sck oe slave", 32'(sck_oe_o), 32'h0);
    sbits(8'h96, 8);
    wait_bf;
    chk("bf slave", rv, 32'h1);
    sbits(8'h5A, 8);
    wb(1'b0, SSBC_CTRL_OFS, 8'h00);
    chk("overflow", rv, 32'h65);
    wb(1'b0, SSBC_BUF_OFS, 8'h00);
    chk("kept byte", rv, 32'h96);
    wb(1'b1, SSBC_CTRL_OFS, 8'h04);
    wb(1'b1, SSBC_CTRL_OFS, 8'h64);
    chk("sdo oe off", 32'(sdo_oe_o), 32'h0);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    sbits(8'hFF, 3);
    ss_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    sbits(8'hC3, 8);
    chk("sdo oe on", 32'(sdo_oe_o), 32'h1);
    wait_bf;
    wb(1'b0, SSBC_BUF_OFS, 8'h00);
    chk("resync byte", rv, 32'hC3);
    conclude;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude;
  end
endmodule
